// ===== cia_consts.vh
// constants for the cpu interrupt acknowledge block
// assumes inclusion by cia_int_ack.v and the testbench; definitions only
`ifndef CIA_CONSTS_VH
`define CIA_CONSTS_VH

// -------------------------------------------------------------
// processor status word
// -------------------------------------------------------------
`define CIA_PSW_RESET 8'h02
`define CIA_PSW_ACC_EN 7
`define CIA_PSW_SVC_LVL 1

// -------------------------------------------------------------
// vectors
// -------------------------------------------------------------
`define CIA_TRAP_VEC 16'h003E
`define CIA_VEC_BASE 16'h0004

// -------------------------------------------------------------
// register byte offsets
// -------------------------------------------------------------
`define CIA_OFS_PSW 8'h00
`define CIA_OFS_PSW_SET 8'h04
`define CIA_OFS_PSW_CLR 8'h08
`define CIA_OFS_REQ 8'h0C
`define CIA_OFS_MASK 8'h10
`define CIA_OFS_PRIO 8'h14
`define CIA_OFS_STAT 8'h18

// -------------------------------------------------------------
// reset values and status fields
// -------------------------------------------------------------
`define CIA_FLAGS_ONES 32'hFFFFFFFF
`define CIA_STAT_BUSY 0
`define CIA_STAT_DEFER 1
`define CIA_STAT_SRC_LSB 8

`endif

// ===== cia_int_ack.v
// cpu interrupt acknowledge and nesting logic with avalon-mm register slave
// assumes the sequencer stalls while ack_busy is high and reports each
// instruction end with instr_done; stack memory lives outside this block
//
// Added by the designer: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/10ps
`include "cia_consts.vh"

module cia_int_ack #(
   parameter NSRC = 16,
   parameter IDXW = 4
) (
   input wire clk,
   input wire sys_rst,
   input wire [7:0] avs_address,
   input wire avs_read,
   input wire avs_write,
   input wire [31:0] avs_writedata,
   input wire [3:0] avs_byteenable,
   output reg [31:0] avs_readdata,
   output reg avs_waitrequest,
   input wire [NSRC-1:0] src_req,
   input wire instr_done,
   input wire instr_hold,
   input wire acc_on_exec,
   input wire acc_off_exec,
   input wire trap_exec,
   input wire push_status,
   input wire psw_pop,
   input wire [7:0] psw_pop_data,
   input wire [15:0] pc_now,
   output reg ack_busy,
   output reg stk_push,
   output reg stk_pc,
   output reg [15:0] stk_data,
   output reg vec_load,
   output reg [15:0] vec_addr,
   output reg [IDXW-1:0] ack_src,
   output reg [7:0] processor_status_word
);

   // ----------------------------------------------------------
   // sequencer states and service kinds
   // ----------------------------------------------------------
   localparam ST_IDLE = 3'b000;
   localparam ST_LOW = 3'b001;
   localparam ST_PSW = 3'b010;
   localparam ST_PC = 3'b011;
   localparam ST_VEC = 3'b100;

   localparam K_MASK = 2'b00;
   localparam K_TRAP = 2'b01;
   localparam K_PUSH = 2'b10;
   localparam [31:0] FLAGS_ONES = `CIA_FLAGS_ONES;

   // ----------------------------------------------------------
   // state
   // ----------------------------------------------------------
   reg [2:0] state_q;
   reg [1:0] kind_q;
   reg [IDXW-1:0] sel_q;
   reg sel_low_q;
   reg defer_q;
   reg [NSRC-1:0] req_q;
   reg [NSRC-1:0] mask_q;
   reg [NSRC-1:0] prio_q;

   // ----------------------------------------------------------
   // bus decode
   // ----------------------------------------------------------
   wire bus_req = avs_read | avs_write;
   wire wr_go = avs_write & ~avs_waitrequest;
   wire [31:0] wmask32 = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                          {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
   wire [NSRC-1:0] wmask = wmask32[NSRC-1:0];
   wire [NSRC-1:0] wdat = avs_writedata[NSRC-1:0];
   wire wr_psw = wr_go & avs_byteenable[0] & (avs_address == `CIA_OFS_PSW);
   wire wr_set = wr_go & avs_byteenable[0] & (avs_address == `CIA_OFS_PSW_SET);
   wire wr_clr = wr_go & avs_byteenable[0] & (avs_address == `CIA_OFS_PSW_CLR);
   wire wr_req = wr_go & (avs_address == `CIA_OFS_REQ);
   wire wr_mask = wr_go & (avs_address == `CIA_OFS_MASK);
   wire wr_prio = wr_go & (avs_address == `CIA_OFS_PRIO);

   // ----------------------------------------------------------
   // acceptance and arbitration
   // ----------------------------------------------------------
   function [IDXW-1:0] first_one;
      input [NSRC-1:0] v;
      integer k;
      begin
         first_one = {IDXW{1'b0}};
         // lowest index is the highest default priority
         for (k = NSRC - 1; k >= 0; k = k - 1) begin
            if (v[k]) begin
               first_one = k[IDXW-1:0];
            end
         end
      end
   endfunction

   wire acc_en = processor_status_word[`CIA_PSW_ACC_EN];
   wire svc_lvl = processor_status_word[`CIA_PSW_SVC_LVL];
   wire [NSRC-1:0] acc = req_q & ~mask_q;
   wire [NSRC-1:0] acc_hi = acc & ~prio_q;
   wire [NSRC-1:0] acc_lo = acc & prio_q & {NSRC{svc_lvl}};
   // boundary after a non-deferring instruction with no deferral standing
   wire at_bound = (state_q == ST_IDLE) & instr_done & ~instr_hold & ~defer_q
                   & ~trap_exec;
   wire any_acc = (|acc_hi) | (|acc_lo);
   wire take = at_bound & acc_en & any_acc;
   wire take_low = ~(|acc_hi);
   wire [IDXW-1:0] pick = take_low ? first_one(acc_lo)
                                   : first_one(acc_hi);
   wire start_trap = (state_q == ST_IDLE) & trap_exec;
   wire start_push = (state_q == ST_IDLE) & push_status & ~trap_exec;

   // ----------------------------------------------------------
   // request flags: hardware set beats every clear
   // ----------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < NSRC; gi = gi + 1) begin : g_req
         wire acc_clr = (state_q == ST_VEC) & (kind_q == K_MASK) &
                        ({{(32-IDXW){1'b0}}, sel_q} == gi);
         always @(posedge clk or posedge sys_rst) begin
            if (sys_rst) begin
               req_q[gi] <= 1'b0;
            end else if (src_req[gi]) begin
               req_q[gi] <= 1'b1;
            end else if (acc_clr) begin
               req_q[gi] <= 1'b0;
            end else if (wr_req & wmask[gi]) begin
               req_q[gi] <= wdat[gi];
            end
         end
      end
   endgenerate

   // ----------------------------------------------------------
   // mask and priority flags
   // ----------------------------------------------------------
   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         mask_q <= FLAGS_ONES[NSRC-1:0];
         prio_q <= FLAGS_ONES[NSRC-1:0];
      end else begin
         if (wr_mask) begin
            mask_q <= (mask_q & ~wmask) | (wdat & wmask);
         end
         if (wr_prio) begin
            prio_q <= (prio_q & ~wmask) | (wdat & wmask);
         end
      end
   end

   // ----------------------------------------------------------
   // deferral after status and flag instructions or returns
   // ----------------------------------------------------------
   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         defer_q <= 1'b0;
      end else if (instr_done) begin
         defer_q <= instr_hold;
      end
   end

   // ----------------------------------------------------------
   // service sequencer
   // ----------------------------------------------------------
   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_q <= ST_IDLE;
         kind_q <= K_MASK;
         sel_q <= {IDXW{1'b0}};
         sel_low_q <= 1'b0;
      end else begin
         case (state_q)
            ST_IDLE: begin
               if (start_trap) begin
                  kind_q <= K_TRAP;
                  state_q <= ST_PSW;
               end else if (take) begin
                  kind_q <= K_MASK;
                  sel_q <= pick;
                  sel_low_q <= take_low;
                  // low level costs one extra clock
                  state_q <= take_low ? ST_LOW : ST_PSW;
               end else if (start_push) begin
                  kind_q <= K_PUSH;
                  state_q <= ST_PSW;
               end
            end
            ST_LOW: begin
               state_q <= ST_PSW;
            end
            ST_PSW: begin
               state_q <= (kind_q == K_PUSH) ? ST_IDLE : ST_PC;
            end
            ST_PC: begin
               state_q <= ST_VEC;
            end
            ST_VEC: begin
               state_q <= ST_IDLE;
            end
            default: begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end

   // ----------------------------------------------------------
   // stack and vector outputs
   // ----------------------------------------------------------
   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         stk_push <= 1'b0;
         stk_pc <= 1'b0;
         stk_data <= 16'h0000;
         vec_load <= 1'b0;
         vec_addr <= 16'h0000;
         ack_src <= {IDXW{1'b0}};
         ack_busy <= 1'b0;
      end else begin
         stk_push <= 1'b0;
         stk_pc <= 1'b0;
         vec_load <= 1'b0;
         ack_busy <= (state_q != ST_IDLE) | start_trap | take | start_push;
         case (state_q)
            ST_PSW: begin
               // status word goes first, pc second
               stk_push <= 1'b1;
               stk_data <= {8'h00, processor_status_word};
            end
            ST_PC: begin
               stk_push <= 1'b1;
               stk_pc <= 1'b1;
               stk_data <= pc_now;
            end
            ST_VEC: begin
               vec_load <= 1'b1;
               ack_src <= sel_q;
               if (kind_q == K_TRAP) begin
                  vec_addr <= `CIA_TRAP_VEC;
               end else begin
                  vec_addr <= `CIA_VEC_BASE + {{(15-IDXW){1'b0}}, sel_q, 1'b0};
               end
            end
            default: begin
               stk_data <= stk_data;
            end
         endcase
      end
   end

   // ----------------------------------------------------------
   // status word
   // ----------------------------------------------------------
   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         processor_status_word <= `CIA_PSW_RESET;
      end else if (state_q == ST_VEC) begin
         // any accept drops enable, so nesting needs a new enable
         processor_status_word[`CIA_PSW_ACC_EN] <= 1'b0;
         if (kind_q == K_MASK) begin
            processor_status_word[`CIA_PSW_SVC_LVL] <= sel_low_q;
         end
      end else if (psw_pop) begin
         // maskable return, trap return and pop all reload here
         processor_status_word <= psw_pop_data;
      end else if (acc_on_exec) begin
         processor_status_word[`CIA_PSW_ACC_EN] <= 1'b1;
      end else if (acc_off_exec) begin
         processor_status_word[`CIA_PSW_ACC_EN] <= 1'b0;
      end else if (wr_psw) begin
         processor_status_word <= avs_writedata[7:0];
      end else if (wr_set) begin
         processor_status_word <= processor_status_word | avs_writedata[7:0];
      end else if (wr_clr) begin
         processor_status_word <= processor_status_word & ~avs_writedata[7:0];
      end
   end

   // ----------------------------------------------------------
   // avalon slave: one wait cycle, then the answer
   // ----------------------------------------------------------
   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         avs_waitrequest <= 1'b1;
         avs_readdata <= 32'h00000000;
      end else if (bus_req & avs_waitrequest) begin
         avs_waitrequest <= 1'b0;
         case (avs_address)
            `CIA_OFS_PSW: begin
               avs_readdata <= {24'h000000, processor_status_word};
            end
            `CIA_OFS_REQ: begin
               avs_readdata <= {{(32-NSRC){1'b0}}, req_q};
            end
            `CIA_OFS_MASK: begin
               avs_readdata <= {{(32-NSRC){1'b0}}, mask_q};
            end
            `CIA_OFS_PRIO: begin
               avs_readdata <= {{(32-NSRC){1'b0}}, prio_q};
            end
            `CIA_OFS_STAT: begin
               avs_readdata <= 32'h00000000;
               avs_readdata[`CIA_STAT_BUSY] <= ack_busy;
               avs_readdata[`CIA_STAT_DEFER] <= defer_q;
               avs_readdata[`CIA_STAT_SRC_LSB+IDXW-1:`CIA_STAT_SRC_LSB] <= ack_src;
            end
            default: begin
               avs_readdata <= 32'h00000000;
            end
         endcase
      end else begin
         avs_waitrequest <= 1'b1;
      end
   end

endmodule

// ===== cia_int_ack_checker.sv
// port checks for cia_int_ack
// assumes a bind onto cia_int_ack; one clock, async active-high reset
`timescale 1ns/10ps
module cia_int_ack_checker #(
   parameter NSRC = 16,
   parameter IDXW = 4
) (
   input wire clk,
   input wire sys_rst,
   input wire avs_read,
   input wire avs_write,
   input wire avs_waitrequest,
   input wire acc_on_exec,
   input wire acc_off_exec,
   input wire trap_exec,
   input wire push_status,
   input wire psw_pop,
   input wire [7:0] psw_pop_data,
   input wire ack_busy,
   input wire stk_push,
   input wire stk_pc,
   input wire [15:0] stk_data,
   input wire vec_load,
   input wire [15:0] vec_addr,
   input wire [IDXW-1:0] ack_src,
   input wire [7:0] processor_status_word
);
   // ----
   // checks
   // ----
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   wire mvec = vec_load && (vec_addr != 16'h003E);
   property p_rst; $past(sys_rst) |-> processor_status_word == 8'h02; endproperty
   a_rst: assert property (p_rst) else $error("bad reset psw");
   property p_bus; (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest; endproperty
   a_bus: assert property (p_bus) else $error("no bus answer");
   property p_en;
      (acc_on_exec ^ acc_off_exec) && !psw_pop && !ack_busy |=> processor_status_word[7] == $past(acc_on_exec);
   endproperty
   a_en: assert property (p_en) else $error("enable bit not set or cleared");
   property p_pop; psw_pop |=> processor_status_word == $past(psw_pop_data); endproperty
   a_pop: assert property (p_pop) else $error("status not reloaded");
   property p_acc; $rose(ack_busy) |-> $past(processor_status_word[7]) || $past(trap_exec) || $past(push_status);
   endproperty
   a_acc: assert property (p_acc) else $error("accept while disabled");
   property p_trap;
      trap_exec && !ack_busy |=> ack_busy ##1 (stk_push && !stk_pc && stk_data == {8'h00, processor_status_word})
         ##1 (stk_push && stk_pc) ##1 (vec_load && vec_addr == 16'h003E && !processor_status_word[7]);
   endproperty
   a_trap: assert property (p_trap) else $error("bad trap sequence");
   property p_stk; stk_push && stk_pc |-> $past(stk_push && !stk_pc); endproperty
   a_stk: assert property (p_stk) else $error("pc pushed before status");
   property p_sts; stk_push && !stk_pc |-> stk_data == {8'h00, processor_status_word}; endproperty
   a_sts: assert property (p_sts) else $error("bad status push data");
   property p_vec; mvec |-> !processor_status_word[7] && vec_addr == 16'h0004 + (16'(ack_src) << 1); endproperty
   a_vec: assert property (p_vec) else $error("bad vector or enable");
   property p_lat;
      mvec |-> (processor_status_word[1] ? ($past(ack_busy, 4) && !$past(ack_busy, 5) && $past(processor_status_word[1], 5))
         : ($past(ack_busy, 3) && !$past(ack_busy, 4)));
   endproperty
   a_lat: assert property (p_lat) else $error("bad level timing");
   c_trap: cover property (vec_load && vec_addr == 16'h003E);
   c_low: cover property (mvec && processor_status_word[1]);
   c_push: cover property ($rose(ack_busy) && $past(push_status));
endmodule

// ===== cia_seq_model.sv
// sequencer model: instruction ends and a status stack
// assumes it stalls while ack_busy is high
`timescale 1ns/10ps
module cia_seq_model (
   input wire clk,
   input wire sys_rst,
   input wire ack_busy,
   input wire stk_push,
   input wire stk_pc,
   input wire psw_pop,
   input wire [15:0] stk_data,
   output wire instr_done,
   output reg [15:0] pc_now,
   output wire [7:0] saved_psw
);
   // ----
   // model
   // ----
   reg [1:0] cnt_q;
   reg [2:0] sp_q;
   reg [7:0] stk_q [0:7];
   assign instr_done = (cnt_q == 2'd3) && !ack_busy;
   assign saved_psw = stk_q[sp_q - 3'd1];
   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         cnt_q <= 2'd0;
         sp_q <= 3'd0;
         pc_now <= 16'h0100;
      end else begin
         if (!ack_busy) cnt_q <= cnt_q + 2'd1;
         if (instr_done) pc_now <= pc_now + 16'h0001;
         if (stk_push && !stk_pc) begin
            stk_q[sp_q] <= stk_data[7:0];
            sp_q <= sp_q + 3'd1;
         end else if (psw_pop) sp_q <= sp_q - 3'd1;
      end
   end
endmodule

// ===== tb_top.sv
// testbench for cia_int_ack with sequencer model
// assumes cia_consts.vh on the include path
`timescale 1ns/10ps
`include "cia_consts.vh"
module tb_top;
   // ----
   // bench
   // ----
   localparam NSRC = 16;
   localparam IDXW = 4;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [7:0] avs_address = 8'h00;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [NSRC-1:0] src_req = '0;
   logic instr_hold = 1'b0;
   logic [4:0] ctl = 5'h00;
   wire [31:0] avs_readdata;
   wire avs_waitrequest, instr_done, ack_busy, stk_push, stk_pc, vec_load;
   wire [15:0] pc_now, stk_data, vec_addr;
   wire [7:0] processor_status_word, saved_psw;
   wire [IDXW-1:0] ack_src;
   int n_mismatch = 0;
   int n_compared = 0;
   int seed = 27;
   int k;
   logic [31:0] rq [$];
   logic [31:0] rm [$];
   logic [23:0] vq [$];
   logic [7:0] sq [$];
   logic [7:0] ep;
   always #50 clk = ~clk;
   cia_int_ack #(.NSRC(NSRC), .IDXW(IDXW)) u_cia_int_ack (
      .clk(clk), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .src_req(src_req),
      .instr_done(instr_done), .instr_hold(instr_hold), .acc_on_exec(ctl[4]),
      .acc_off_exec(ctl[3]),
      .trap_exec(ctl[2]), .push_status(ctl[1]), .psw_pop(ctl[0]), .psw_pop_data(saved_psw),
      .pc_now(pc_now), .ack_busy(ack_busy), .stk_push(stk_push), .stk_pc(stk_pc),
      .stk_data(stk_data), .vec_load(vec_load), .vec_addr(vec_addr), .ack_src(ack_src),
      .processor_status_word(processor_status_word));
   cia_seq_model u_cia_seq_model (.clk(clk), .sys_rst(sys_rst), .ack_busy(ack_busy),
      .stk_push(stk_push), .stk_pc(stk_pc), .psw_pop(ctl[0]), .stk_data(stk_data),
      .instr_done(instr_done), .pc_now(pc_now), .saved_psw(saved_psw));
   task check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      n_compared++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t: %s got %h exp %h", $time, what, seen, exp);
      end
   endtask
   task complete_run;
      $display("compared %0d mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task hang(input string what);
      n_mismatch++;
      $display("mismatch at %0t: %s timed out", $time, what);
      complete_run();
   endtask
   task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      int j;
      @(posedge clk);
      avs_address <= a;
      avs_read <= !w;
      avs_write <= w;
      avs_writedata <= d;
      for (j = 0; j < 20; j++) begin
         @(posedge clk);
         if (!avs_waitrequest) break;
      end
      if (j == 20) hang("bus");
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   task rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
      rq.push_back(e);
      rm.push_back(m);
      bus(1'b0, a, 32'h0);
   endtask
   task pulse(input logic [4:0] v);
      @(posedge clk);
      ctl <= v;
      @(posedge clk);
      ctl <= 5'h00;
   endtask
   task req(input logic [15:0] v);
      @(posedge clk);
      src_req <= v;
      @(posedge clk);
      src_req <= '0;
   endtask
   task en(input logic on);
      ep[7] = on;
      pulse(on ? 5'h10 : 5'h08);
   endtask
   task acc(input logic [15:0] vec, input logic lvl);
      sq.push_back(ep);
      ep = {1'b0, ep[6:2], lvl, ep[0]};
      vq.push_back({vec, ep});
   endtask
   task ret;
      pulse(5'h01);
      ep = sq.pop_back();
      @(posedge clk);
      check({24'h0, processor_status_word}, {24'h0, ep}, "status after return");
   endtask
   task done_wait;
      int j;
      for (j = 0; j < 300 && vq.size() != 0; j++) @(posedge clk);
      if (vq.size() != 0) hang("vector");
      for (j = 0; j < 20 && ack_busy !== 1'b0; j++) @(posedge clk);
      if (j == 20) hang("busy");
   endtask
   always @(posedge clk) begin
      if (avs_read && !avs_waitrequest && rq.size() != 0)
         check(avs_readdata & rm.pop_front(), rq.pop_front(), "read");
      if (vec_load)
         check({8'h0, vec_addr, processor_status_word}, vq.size() ? {8'h0, vq.pop_front()} : 32'hFFFFFFFF,
            "vector");
   end
   initial begin
      repeat (4) @(posedge clk);
      sys_rst <= 1'b0;
      k = 8 + ($unsigned($random(seed)) % 8);
      ep = 8'h02;
      rd(`CIA_OFS_PSW, 32'h02, 32'hFF);
      rd(`CIA_OFS_PRIO, 32'hFFFF, 32'hFFFF);
      rd(8'h1C, 32'h0, 32'hFFFFFFFF);
      bus(1'b1, `CIA_OFS_PSW, 32'h42);
      rd(`CIA_OFS_PSW, 32'h42, 32'hFF);
      bus(1'b1, `CIA_OFS_PSW_SET, 32'h01);
      rd(`CIA_OFS_PSW, 32'h43, 32'hFF);
      bus(1'b1, `CIA_OFS_PSW_CLR, 32'h41);
      rd(`CIA_OFS_PSW, 32'h02, 32'hFF);
      bus(1'b1, `CIA_OFS_MASK, ~(32'h26 | (32'h1 << k)));
      bus(1'b1, `CIA_OFS_PRIO, ~(32'h20 | (32'h1 << k)));
      req((16'h1 << k) | 16'h0001);
      repeat (20) @(posedge clk);
      rd(`CIA_OFS_REQ, (32'h1 << k) | 32'h1, 32'hFFFF);
      en(1'b1);
      acc(16'(4 + 2 * k), 1'b0);
      done_wait();
      req(16'h0026);
      repeat (20) @(posedge clk);
      ret();
      acc(16'h000E, 1'b0);
      done_wait();
      en(1'b1);
      repeat (24) @(posedge clk);
      ret();
      acc(16'h0006, 1'b1);
      done_wait();
      ret();
      acc(16'h0008, 1'b1);
      done_wait();
      ret();
      en(1'b0);
      acc(16'h003E, ep[1]);
      pulse(5'h04);
      done_wait();
      en(1'b1);
      acc(16'h0006, 1'b1);
      req(16'h0002);
      done_wait();
      ret();
      ret();
      pulse(5'h02);
      done_wait();
      en(1'b1);
      instr_hold <= 1'b1;
      req(16'h0020);
      repeat (24) @(posedge clk);
      acc(16'h000E, 1'b0);
      instr_hold <= 1'b0;
      done_wait();
      ret();
      complete_run();
   end
   initial begin
      repeat (60000) @(posedge clk);
      hang("run");
   end
endmodule
bind cia_int_ack cia_int_ack_checker #(.NSRC(NSRC), .IDXW(IDXW)) u_cia_int_ack_checker (
   .clk(clk), .sys_rst(sys_rst), .avs_read(avs_read), .avs_write(avs_write),
   .avs_waitrequest(avs_waitrequest), .acc_on_exec(acc_on_exec),
   .acc_off_exec(acc_off_exec),
   .trap_exec(trap_exec), .push_status(push_status), .psw_pop(psw_pop),
   .psw_pop_data(psw_pop_data), .ack_busy(ack_busy), .stk_push(stk_push), .stk_pc(stk_pc),
   .stk_data(stk_data), .vec_load(vec_load), .vec_addr(vec_addr), .ack_src(ack_src),
   .processor_status_word(processor_status_word));
